// ### rtl/lfsc_glitch_filt.sv
// one-bit glitch filter: output follows the input once it has held steady for CYC cycles
// assumes the raw input is already synchronous to clk_i
`default_nettype none
module lfsc_glitch_filt
	import lfsc_pkg::*;
#(
	parameter int unsigned CYC = CMP_FILT_CYC
) (
	input wire logic clk_i,   // system clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic raw_i,   // unfiltered level
	output logic filt_o       // qualified level
);
	logic [FILT_W-1:0] cnt_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (raw_i == filt_o || cnt_r == FILT_W'(CYC - 1)) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + FILT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			filt_o <= 1'b0;
		end else if (raw_i != filt_o && cnt_r == FILT_W'(CYC - 1)) begin
			filt_o <= raw_i;
		end
	end
endmodule
`default_nettype wire

// ### rtl/lfsc_pkg.sv
// constants shared by the LED driver fault and state control logic
// assumes a single 50 MHz clock; filter, enable and adaptation times become cycle counts here, fault timers in lfsc_top
`default_nettype none
package lfsc_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;

	localparam int unsigned NCH = 4;
	localparam int unsigned VT_W = 8;
	localparam int unsigned CNT_W = 25;
	localparam int unsigned FILT_W = 6;
	localparam int unsigned EN_W = 11;

	// comparator filter time, a least time: rounded up
	localparam int unsigned T_CMP_FILT_NS = 1000;
	localparam int unsigned CMP_FILT_CYC = (T_CMP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// enable clearing pulse window: least time rounded up, longest rounded down
	localparam int unsigned T_EN_MIN_NS = 2000;
	localparam int unsigned T_EN_MAX_NS = 20000;
	localparam int unsigned EN_MIN_CYC = (T_EN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EN_MAX_CYC = T_EN_MAX_NS / CLK_PERIOD_NS;
	// fault filters and timers
	localparam int unsigned T_OV_SS_US = 100;
	localparam int unsigned T_UV_US = 100;
	localparam int unsigned T_OV_ACT_MS = 560;
	localparam int unsigned T_OV_RPT_MS = 50;
	localparam int unsigned T_OV_REARM_MS = 160;
	localparam int unsigned T_RECOVERY_MS = 100;
	localparam int unsigned T_SOFT_START_US = 1000;
	localparam int unsigned T_ADAPT_NS = 10000;
	localparam int unsigned ADAPT_CYC = T_ADAPT_NS / CLK_PERIOD_NS;

	// target voltage code: 256 levels between minimum and maximum output voltage
	localparam logic [VT_W-1:0] VT_MAX = 8'hFF;
	localparam logic [VT_W-1:0] VT_MIN = 8'h00;
	localparam logic [VT_W-1:0] VT_INIT = 8'hE1;
	localparam logic [VT_W-1:0] VT_ONE = 8'h01;
	// down pressure applied once every DP_TICKS + 1 adaptation ticks
	localparam logic [3:0] DP_TICKS = 4'hF;

	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_SOFT,
		ST_ACTIVE,
		ST_RECOVERY
	} lfsc_state_t;
endpackage
`default_nettype wire

// ### rtl/lfsc_top.sv
// LED driver control: PWM pass-through, adaptive target voltage, string faults, state machine
// assumes all inputs synchronous to clk_i; rst_n_i is the regulator power-on reset
// Behaviour
// - each enabled channel output follows the brightness PWM input edge for edge.
// - converter target is an 8-bit code of 256 levels, 255 equal voltage steps.
// - target code is nudged down periodically even in steady state.
// - three headroom comparator flags per channel, each filtered for 1 us.
// - target holds between periodic down steps while all active channels sit between low and mid.
// - target steps down when all active channels are above mid.
// - target steps up when any active channel is below low.
// - open string fault when code is maximum and a channel stays below low.
// - short fault when a channel is above high while another is in window.
// - string fault disables only that channel, asserts fault, stays active.
// - overvoltage, undervoltage or thermal fault enters recovery; all off, fault low.
// - after 100 ms recovery, return active if fault cleared; release fault.
// - enable low 2 to 20 us clears string fault indication, not the disabled channel; LEDs blanked meanwhile.
// - enable low longer than the window enters standby; restart on enable high.
// - from soft start, overvoltage faults after persisting 100 us.
// - active overvoltage filter 560 ms, 50 ms after a fault, rearmed after 160 ms.
// - undervoltage watched in every state, faults after persisting 100 us.
// - thermal flag watched from soft start; recovery waits until it clears.
// - standby after power-on reset; power up when enable goes high.
// - grounded outputs found at each power up from standby, disabled and excluded until the next.
`default_nettype none
module lfsc_top
	import lfsc_pkg::*;
#(
	parameter int unsigned OV_SS_CYC = T_OV_SS_US * CYC_PER_US,
	parameter int unsigned UV_CYC = T_UV_US * CYC_PER_US,
	parameter int unsigned OV_ACT_CYC = T_OV_ACT_MS * CYC_PER_MS,
	parameter int unsigned OV_RPT_CYC = T_OV_RPT_MS * CYC_PER_MS,
	parameter int unsigned OV_REARM_CYC = T_OV_REARM_MS * CYC_PER_MS,
	parameter int unsigned REC_CYC = T_RECOVERY_MS * CYC_PER_MS,
	parameter int unsigned SOFT_CYC = T_SOFT_START_US * CYC_PER_US
) (
	input wire logic clk_i,                // 50 MHz clock
	input wire logic rst_n_i,              // power-on reset, active low
	input wire logic enable_input,         // host enable level
	input wire logic pwm_i,                // host brightness PWM
	input wire logic [NCH-1:0] low_cmp_i,  // channel above low headroom level
	input wire logic [NCH-1:0] mid_cmp_i,  // channel above mid headroom level
	input wire logic [NCH-1:0] high_cmp_i, // channel above shorted-string level
	input wire logic [NCH-1:0] grounded_i, // output sensed tied to ground
	input wire logic ovp_i,                // raw input overvoltage condition
	input wire logic uvlo_i,               // raw input undervoltage condition
	input wire logic tsd_i,                // thermal flag, hysteresis done in analog
	input wire logic fault_pin_i,          // fault pin level, not used inside
	output logic [NCH-1:0] led_pwm_o,      // current sink enables
	output logic conv_en_o,                // converter enable
	output logic [VT_W-1:0] vtarget_o,     // converter target voltage code
	output logic fault_pin_o,              // fault pin drive value, always low
	output logic fault_oe_n_o,             // fault pin enable, low pulls pin low
	output logic [NCH-1:0] open_string_fault_o,   // latched open-string channels
	output logic [NCH-1:0] shorted_string_fault_o // latched shorted-string channels
);
	lfsc_state_t state_r;
	lfsc_state_t state_nxt;
	logic [NCH-1:0] low_f, mid_f, high_f;
	logic [NCH-1:0] gnd_r, open_r, short_r, act;
	logic [CNT_W-1:0] st_cnt_r, ov_cnt_r, uv_cnt_r, rearm_cnt_r;
	logic [EN_W-1:0] en_lo_cnt_r;
	logic [9:0] tick_cnt_r;
	logic [3:0] dp_cnt_r;
	logic tick, dp, any_low, all_mid, open_hit, in_win, ov_fast_r, led_fault_r;
	logic ov_flt, uv_flt, hard_flt, en_clear, en_long, rec_done, soft_done;
	logic [NCH-1:0] short_hit;

	genvar g;
	for (g = 0; g < NCH; g++) begin : g_cmp
		lfsc_glitch_filt #(.CYC(CMP_FILT_CYC)) u_low (
			.clk_i(clk_i), .rst_n_i(rst_n_i), .raw_i(low_cmp_i[g]), .filt_o(low_f[g]));
		lfsc_glitch_filt #(.CYC(CMP_FILT_CYC)) u_mid (
			.clk_i(clk_i), .rst_n_i(rst_n_i), .raw_i(mid_cmp_i[g]), .filt_o(mid_f[g]));
		lfsc_glitch_filt #(.CYC(CMP_FILT_CYC)) u_high (
			.clk_i(clk_i), .rst_n_i(rst_n_i), .raw_i(high_cmp_i[g]), .filt_o(high_f[g]));
	end

	function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input int unsigned lim);
		cnt_hit = (cnt >= CNT_W'(lim - 1));
	endfunction

	// faulted and grounded channels drop out of the loop
	assign act = ~(gnd_r | open_r | short_r);
	assign any_low = |(act & ~low_f);
	assign all_mid = (act != '0) && ((act & ~mid_f) == '0);
	assign in_win = |(act & low_f & ~mid_f);
	// high on one, another in window
	assign short_hit = (act & high_f) & {NCH{in_win}};
	assign open_hit = any_low && vtarget_o == VT_MAX;
	// comparators only mean something while the sinks conduct
	assign tick = state_r == ST_ACTIVE && pwm_i && enable_input && tick_cnt_r == 10'(ADAPT_CYC - 1);
	assign dp = dp_cnt_r == DP_TICKS;

	// enable low measured; short pulse clears
	assign en_clear = enable_input && en_lo_cnt_r >= EN_W'(EN_MIN_CYC) && en_lo_cnt_r <= EN_W'(EN_MAX_CYC);
	assign en_long = !enable_input && en_lo_cnt_r == EN_W'(EN_MAX_CYC);

	// overvoltage filter length depends on state and history
	always_comb begin
		ov_flt = 1'b0;
		if (state_r == ST_SOFT) begin
			ov_flt = ovp_i && cnt_hit(ov_cnt_r, OV_SS_CYC);
		end else if (state_r == ST_ACTIVE) begin
			ov_flt = ovp_i && cnt_hit(ov_cnt_r, ov_fast_r ? OV_RPT_CYC : OV_ACT_CYC);
		end
	end
	assign uv_flt = uvlo_i && cnt_hit(uv_cnt_r, UV_CYC);
	assign hard_flt = ov_flt || uv_flt || tsd_i;
	assign rec_done = cnt_hit(st_cnt_r, REC_CYC);
	assign soft_done = cnt_hit(st_cnt_r, SOFT_CYC);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_STANDBY: begin
				if (enable_input && !uvlo_i) begin
					state_nxt = ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (en_long) begin
					state_nxt = ST_STANDBY;
				end else if (hard_flt) begin
					state_nxt = ST_RECOVERY;
				end else if (soft_done) begin
					state_nxt = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (en_long) begin
					state_nxt = ST_STANDBY;
				end else if (hard_flt) begin
					state_nxt = ST_RECOVERY;
				end
			end
			ST_RECOVERY: begin
				if (en_long) begin
					state_nxt = ST_STANDBY;
				end else if (rec_done && !ovp_i && !uvlo_i && !tsd_i) begin
					state_nxt = ST_ACTIVE;
				end
			end
			default: state_nxt = ST_STANDBY;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_STANDBY;
		end else begin
			state_r <= state_nxt;
		end
	end

	// time in state; restarts on entry and on each failed recovery attempt
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_cnt_r <= '0;
		end else if (state_nxt != state_r || (state_r == ST_RECOVERY && rec_done)) begin
			st_cnt_r <= '0;
		end else if (!cnt_hit(st_cnt_r, REC_CYC) || !cnt_hit(st_cnt_r, SOFT_CYC)) begin
			st_cnt_r <= st_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ov_cnt_r <= '0;
		end else if (!ovp_i || state_nxt != state_r || !(state_r == ST_SOFT || state_r == ST_ACTIVE)) begin
			ov_cnt_r <= '0;
		end else if (!cnt_hit(ov_cnt_r, OV_ACT_CYC)) begin
			ov_cnt_r <= ov_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			uv_cnt_r <= '0;
		end else if (!uvlo_i) begin
			uv_cnt_r <= '0;
		end else if (!uv_flt) begin
			uv_cnt_r <= uv_cnt_r + CNT_W'(1);
		end
	end

	// shortened filter after a fault, rearmed after 160 ms active
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ov_fast_r <= 1'b0;
		end else if (ov_flt) begin
			ov_fast_r <= 1'b1;
		end else if (state_r == ST_ACTIVE && cnt_hit(rearm_cnt_r, OV_REARM_CYC)) begin
			ov_fast_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rearm_cnt_r <= '0;
		end else if (state_r != ST_ACTIVE) begin
			rearm_cnt_r <= '0;
		end else if (!cnt_hit(rearm_cnt_r, OV_REARM_CYC)) begin
			rearm_cnt_r <= rearm_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_lo_cnt_r <= '0;
		end else if (enable_input) begin
			en_lo_cnt_r <= '0;
		end else if (en_lo_cnt_r != EN_W'(EN_MAX_CYC)) begin
			en_lo_cnt_r <= en_lo_cnt_r + EN_W'(1);
		end
	end

	// grounded outputs sampled once at start of soft start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gnd_r <= '0;
		end else if (state_r == ST_STANDBY && state_nxt == ST_SOFT) begin
			gnd_r <= grounded_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= '0;
		end else if (state_r != ST_ACTIVE || tick_cnt_r == 10'(ADAPT_CYC - 1)) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 10'd1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dp_cnt_r <= '0;
		end else if (tick) begin
			dp_cnt_r <= dp ? 4'h0 : dp_cnt_r + 4'h1;
		end
	end

	// 256-level code; restarts from the initial level on power up
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vtarget_o <= VT_INIT;
		end else if (state_r == ST_STANDBY) begin
			vtarget_o <= VT_INIT;
		end else if (tick) begin
			if (any_low) begin
				if (vtarget_o != VT_MAX) begin
					vtarget_o <= vtarget_o + VT_ONE;
				end
			// all above mid, or periodic down pressure
			end else if ((all_mid || dp) && vtarget_o != VT_MIN) begin
				vtarget_o <= vtarget_o - VT_ONE;
			end
		end
	end

	// open string at maximum code; shorted string; both stay until standby
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			open_r <= '0;
			short_r <= '0;
		end else if (state_r == ST_STANDBY) begin
			open_r <= '0;
			short_r <= '0;
		end else if (tick) begin
			open_r <= open_r | (open_hit ? (act & ~low_f) : '0);
			short_r <= short_r | short_hit;
		end
	end
	assign open_string_fault_o = open_r;
	assign shorted_string_fault_o = short_r;

	// latched string fault indication; set wins over the clearing pulse
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_fault_r <= 1'b0;
		end else if (tick && (open_hit || short_hit != '0)) begin
			led_fault_r <= 1'b1;
		end else if (en_clear || state_r == ST_STANDBY) begin
			led_fault_r <= 1'b0;
		end
	end

	// pin low in recovery or on string fault, released otherwise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_oe_n_o <= 1'b1;
			fault_pin_o <= 1'b0;
		end else begin
			fault_oe_n_o <= !(state_nxt == ST_RECOVERY || led_fault_r);
			fault_pin_o <= 1'b0;
		end
	end

	// sinks follow PWM; blanked while enable is low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_pwm_o <= '0;
			conv_en_o <= 1'b0;
		end else begin
			led_pwm_o <= (state_nxt == ST_ACTIVE && enable_input && pwm_i) ? act : '0;
			conv_en_o <= state_nxt == ST_SOFT || state_nxt == ST_ACTIVE;
		end
	end

	sequence s_clear_pulse;
		!enable_input [*2] ##1 en_clear;
	endsequence

	property p_pwm_follow;
		@(posedge clk_i) disable iff (!rst_n_i) led_pwm_o != '0 |-> $past(pwm_i) && $past(enable_input);
	endproperty
	a_pwm_follow: assert property (p_pwm_follow) else $error("sink on without pwm");

	property p_step_up;
		@(posedge clk_i) disable iff (!rst_n_i)
		tick && any_low && vtarget_o != VT_MAX |=> vtarget_o == $past(vtarget_o) + VT_ONE;
	endproperty
	a_step_up: assert property (p_step_up) else $error("target did not step up");

	property p_step_down;
		@(posedge clk_i) disable iff (!rst_n_i)
		tick && !any_low && all_mid && vtarget_o != VT_MIN |=> vtarget_o == $past(vtarget_o) - VT_ONE;
	endproperty
	a_step_down: assert property (p_step_down) else $error("target did not step down");

	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_ACTIVE && !any_low && !all_mid && !(tick && dp) |=> $stable(vtarget_o);
	endproperty
	a_hold: assert property (p_hold) else $error("target moved inside window");

	property p_open;
		@(posedge clk_i) disable iff (!rst_n_i)
		tick && open_hit |=> led_fault_r && (open_r != '0) && state_r == ST_ACTIVE ##1 !fault_oe_n_o;
	endproperty
	a_open: assert property (p_open) else $error("open string not flagged");

	property p_recovery_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_ACTIVE && hard_flt && !en_long |=> state_r == ST_RECOVERY && !conv_en_o
			&& led_pwm_o == '0 && !fault_oe_n_o;
	endproperty
	a_recovery_off: assert property (p_recovery_off) else $error("hard fault not handled");

	property p_uv;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_ACTIVE && uvlo_i && uv_cnt_r == '0 && !en_long && !ov_flt && !tsd_i |=> state_r == ST_ACTIVE;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage tripped without filter");

	property p_standby;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_r != ST_STANDBY && en_long |=> state_r == ST_STANDBY ##1 conv_en_o == 1'b0;
	endproperty
	a_standby: assert property (p_standby) else $error("long enable low missed standby");

	property p_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_clear_pulse and ##2 !(tick && (open_hit || short_hit != '0)) |=> !led_fault_r;
	endproperty
	a_clear: assert property (p_clear) else $error("clearing pulse ignored");

	property p_ground;
		@(posedge clk_i) disable iff (!rst_n_i) (led_pwm_o & gnd_r) == '0;
	endproperty
	a_ground: assert property (p_ground) else $error("grounded channel driven");
endmodule
`default_nettype wire

// ### verif/lfsc_host_model.sv
// host controller model: drives the enable and brightness PWM pins of the LED driver
// assumes the bench calls its tasks; pins change only at the falling clock edge
`default_nettype none
module lfsc_host_model (
	input wire logic clk_i, // system clock, used only to time pin changes
	output logic enable_o,  // enable pin level
	output logic pwm_o      // brightness PWM level
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		enable_o = 1'b0;
		pwm_o = 1'b0;
	end

	// host pwm pacing
	// levels are held for whole cycles; the bench keeps periods well inside the allowed range
	task automatic drive_pwm(input logic v);
		@(negedge clk_i);
		pwm_o = v;
	endtask

	// host enable pulses
	// pulse length is counted by the caller in cycles, so short and long lows are both possible
	task automatic drive_en(input logic v);
		@(negedge clk_i);
		enable_o = v;
	endtask
endmodule
`default_nettype wire

// ### verif/lfsc_top_tb.sv
// self-checking bench for the LED driver fault and state control
// assumes shortened fault timers; the host model drives enable and PWM, the bench the analog flags
`default_nettype none
module lfsc_top_tb;
	import lfsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WD_CYC = 80000;
	localparam int REC = 100;
	localparam int SOFT = 50;
	localparam int OV_ACT = 150;
	localparam int OV_RPT = 60;
	localparam int REARM = 200;
	// undervoltage filter left at its real length: it is short enough to run in full
	localparam int UV = T_UV_US * CYC_PER_US;

	typedef struct {
		logic pwm;
		logic [3:0] led;
	} lfsc_row_t;

	logic clk_i, rst_n_i, enable_input, pwm_i, ovp_i, uvlo_i, tsd_i, fault_pin_i;
	logic [NCH-1:0] low_cmp_i, mid_cmp_i, high_cmp_i, grounded_i, led_pwm_o, open_o, short_o;
	logic conv_en_o, fault_pin_o, fault_oe_n_o;
	logic [VT_W-1:0] vtarget_o, v0;
	int miscompares, total_checks;
	lfsc_row_t rows[4];

	// open-drain pin with pull-up
	assign fault_pin_i = fault_oe_n_o ? 1'b1 : fault_pin_o;

	lfsc_host_model lfsc_host_model_inst (.clk_i(clk_i), .enable_o(enable_input), .pwm_o(pwm_i));

	lfsc_top #(.OV_ACT_CYC(OV_ACT), .OV_RPT_CYC(OV_RPT), .OV_REARM_CYC(REARM),
		.REC_CYC(REC), .SOFT_CYC(SOFT)) lfsc_top_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_input(enable_input), .pwm_i(pwm_i),
		.low_cmp_i(low_cmp_i), .mid_cmp_i(mid_cmp_i), .high_cmp_i(high_cmp_i), .grounded_i(grounded_i),
		.ovp_i(ovp_i), .uvlo_i(uvlo_i), .tsd_i(tsd_i), .fault_pin_i(fault_pin_i),
		.led_pwm_o(led_pwm_o), .conv_en_o(conv_en_o), .vtarget_o(vtarget_o), .fault_pin_o(fault_pin_o),
		.fault_oe_n_o(fault_oe_n_o), .open_string_fault_o(open_o), .shorted_string_fault_o(short_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wait_conv(input logic v, input int lim);
		int n;
		n = 0;
		while (conv_en_o !== v && n < lim) begin
			@(negedge clk_i);
			n++;
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(WD_CYC * 20);
		miscompares++;
		end_of_test;
	end

	initial begin
		int n;
		miscompares = 0;
		total_checks = 0;
		rst_n_i = 1'b0;
		ovp_i = 1'b0;
		uvlo_i = 1'b0;
		tsd_i = 1'b0;
		low_cmp_i = 4'hF;
		mid_cmp_i = 4'h0;
		high_cmp_i = 4'h0;
		grounded_i = 4'h8;
		rows = '{'{1'b1, 4'h7}, '{1'b0, 4'h0}, '{1'b0, 4'h0}, '{1'b1, 4'h7}};
		cyc(4);
		chk("reset target", vtarget_o, 8'hE1);
		chk("reset pin", {7'h0, fault_oe_n_o}, 8'h01);
		cyc(4);
		rst_n_i = 1'b1;
		cyc(3);
		chk("standby conv", {7'h0, conv_en_o}, 8'h00);
		lfsc_host_model_inst.drive_en(1'b1);
		cyc(1);
		chk("power up", {7'h0, conv_en_o}, 8'h01);
		chk("soft leds", {4'h0, led_pwm_o}, 8'h00);
		cyc(60);
		// grounded channel 3 never lights
		foreach (rows[i]) begin
			lfsc_host_model_inst.drive_pwm(rows[i].pwm);
			cyc(2);
			chk("pwm follow", {4'h0, led_pwm_o}, {4'h0, rows[i].led});
		end
		v0 = vtarget_o;
		cyc(8 * 500);
		chk("hold", vtarget_o, v0);
		cyc(10 * 500);
		chk("down pressure", vtarget_o, v0 - 8'h01);
		v0 = vtarget_o;
		mid_cmp_i = 4'hF;
		cyc(3 * 500);
		chk("step down", vtarget_o, v0 - 8'h03);
		mid_cmp_i = 4'h0;
		low_cmp_i = 4'hE;
		v0 = vtarget_o;
		cyc(3 * 500);
		chk("step up", vtarget_o, v0 + 8'h03);
		n = 0;
		while (open_o !== 4'h1 && n < 30000) begin
			@(negedge clk_i);
			n++;
		end
		chk("open bit", {4'h0, open_o}, 8'h01);
		chk("open at max", vtarget_o, 8'hFF);
		cyc(3);
		chk("open pin", {7'h0, fault_oe_n_o}, 8'h00);
		chk("pin level", {7'h0, fault_pin_i}, 8'h00);
		chk("open leds", {4'h0, led_pwm_o}, 8'h06);
		mid_cmp_i = 4'h2;
		high_cmp_i = 4'h2;
		n = 0;
		while (short_o !== 4'h2 && n < 1500) begin
			@(negedge clk_i);
			n++;
		end
		chk("short bit", {4'h0, short_o}, 8'h02);
		cyc(3);
		chk("short leds", {4'h0, led_pwm_o}, 8'h04);
		chk("still active", {7'h0, conv_en_o}, 8'h01);
		lfsc_host_model_inst.drive_en(1'b0);
		cyc(20);
		lfsc_host_model_inst.drive_en(1'b1);
		cyc(5);
		chk("glitch pin", {7'h0, fault_oe_n_o}, 8'h00);
		lfsc_host_model_inst.drive_en(1'b0);
		cyc(100);
		chk("blanked", {4'h0, led_pwm_o}, 8'h00);
		cyc(100);
		lfsc_host_model_inst.drive_en(1'b1);
		cyc(5);
		chk("pin released", {7'h0, fault_oe_n_o}, 8'h01);
		chk("active kept", {7'h0, conv_en_o}, 8'h01);
		uvlo_i = 1'b1;
		cyc(UV - 20);
		chk("uv filter", {7'h0, conv_en_o}, 8'h01);
		wait_conv(1'b0, 30);
		chk("uv fault", {7'h0, conv_en_o}, 8'h00);
		chk("uv pin", {7'h0, fault_oe_n_o}, 8'h00);
		chk("uv leds", {4'h0, led_pwm_o}, 8'h00);
		uvlo_i = 1'b0;
		cyc(50);
		chk("rec wait", {7'h0, conv_en_o}, 8'h00);
		wait_conv(1'b1, REC);
		chk("rec done", {7'h0, conv_en_o}, 8'h01);
		cyc(2);
		chk("rec pin", {7'h0, fault_oe_n_o}, 8'h01);
		tsd_i = 1'b1;
		wait_conv(1'b0, 5);
		chk("tsd fault", {7'h0, conv_en_o}, 8'h00);
		cyc(REC + 20);
		chk("tsd held", {7'h0, conv_en_o}, 8'h00);
		tsd_i = 1'b0;
		wait_conv(1'b1, REC + 10);
		chk("tsd back", {7'h0, conv_en_o}, 8'h01);
		ovp_i = 1'b1;
		cyc(100);
		ovp_i = 1'b0;
		chk("ov long filter", {7'h0, conv_en_o}, 8'h01);
		cyc(5);
		ovp_i = 1'b1;
		cyc(140);
		chk("ov before", {7'h0, conv_en_o}, 8'h01);
		wait_conv(1'b0, 20);
		chk("ov fault", {7'h0, conv_en_o}, 8'h00);
		ovp_i = 1'b0;
		wait_conv(1'b1, REC + 10);
		ovp_i = 1'b1;
		cyc(80);
		chk("ov short filter", {7'h0, conv_en_o}, 8'h00);
		ovp_i = 1'b0;
		wait_conv(1'b1, REC + 10);
		// long filter again once active for the rearm time
		cyc(REARM + 5);
		ovp_i = 1'b1;
		cyc(100);
		ovp_i = 1'b0;
		chk("ov rearmed", {7'h0, conv_en_o}, 8'h01);
		lfsc_host_model_inst.drive_en(1'b0);
		cyc(1100);
		chk("standby conv", {7'h0, conv_en_o}, 8'h00);
		chk("standby target", vtarget_o, 8'hE1);
		chk("standby faults", {open_o, short_o}, 8'h00);
		grounded_i = 4'h4;
		lfsc_host_model_inst.drive_en(1'b1);
		cyc(1);
		chk("restart", {7'h0, conv_en_o}, 8'h01);
		cyc(SOFT + 10);
		chk("regrounded leds", {4'h0, led_pwm_o}, 8'h0B);
		end_of_test;
	end
endmodule
`default_nettype wire
